// *** src/pressure_pkg.sv ***
package pressure_pkg;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_PRESSURE = 8'h01;
  localparam logic [7:0] CMD_DYN_ZERO = 8'h02;
  localparam logic [7:0] CMD_UNDO_ZERO = 8'h03;
  localparam logic [7:0] CMD_RANGE = 8'h04;
  localparam logic [7:0] CMD_PART_ID = 8'h05;
  localparam logic [7:0] CMD_SW_REV = 8'h06;
  // ****************************************
  // values and counts
  // ****************************************
  localparam logic [7:0] REPLY_RST = 8'h00;
  localparam logic [7:0] REPLY_UNKNOWN = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [3:0] AVG_LAST = 4'hf;
  localparam int AVG_SHIFT = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : pressure_pkg

// *** src/smart_pressure_spi_slave.sv ***
// Function
// - keep six calibration bytes, two supply points
// - calibration holds digitized supply at both points
// - interpolate zero and span at measured supply
// - pressure samples are unsigned bytes
// - sum sixteen samples, shift right four
// - decode command byte, start matching action
// - command 01 returns compensated pressure byte
// - command 02 captures average as zero
// - command 03 restores calibrated zero offset
// - command 04 returns full-scale range byte
// - part id and revision readable on request
// - reply byte carries previous command result
// - every reply is unsigned byte 0..255
`timescale 1ns/100ps
`default_nettype none
module smart_pressure_spi_slave #(
  parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] SW_REV = 8'h01, // arbitrary value
  parameter logic [7:0] RANGE_CODE = 8'h0a
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_valid_i,
  input wire logic [7:0] sample_i,
  input wire logic [7:0] supply_i,
  input wire logic cal_load_i,
  input wire logic [7:0] cal_zero_lo_i,
  input wire logic [7:0] cal_full_lo_i,
  input wire logic [7:0] cal_supply_lo_i,
  input wire logic [7:0] cal_zero_hi_i,
  input wire logic [7:0] cal_full_hi_i,
  input wire logic [7:0] cal_supply_hi_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output logic dyn_zero_o,
  output logic [7:0] avg_o
);
  import pressure_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    logic mosi_s1;
    logic mosi_s2;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [3:0] bitcnt;
    logic [7:0] reply;
    logic miso;
    logic miso_oe;
    logic [11:0] acc;
    logic [3:0] cnt;
    logic [7:0] avg;
    logic [7:0] vsup;
    logic [7:0] zero_lo;
    logic [7:0] full_lo;
    logic [7:0] sup_lo;
    logic [7:0] zero_hi;
    logic [7:0] full_hi;
    logic [7:0] sup_hi;
    logic dyn;
    logic [7:0] dz;
    logic [7:0] press;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ****************************************
  // compensation arithmetic
  // ****************************************
  // linear interpolation of a calibration value at supply v
  function automatic logic signed [19:0] interp(input logic [7:0] a, input logic [7:0] b,
                                                input logic [7:0] vl, input logic [7:0] vh,
                                                input logic [7:0] v);
    logic signed [19:0] num;
    logic signed [19:0] den;
    num = ($signed({12'h000, b}) - $signed({12'h000, a})) *
          ($signed({12'h000, v}) - $signed({12'h000, vl}));
    den = $signed({12'h000, vh}) - $signed({12'h000, vl});
    if (den == 20'sh00000) begin
      interp = $signed({12'h000, a}); // degenerate calibration
    end else begin
      interp = $signed({12'h000, a}) + num / den;
    end
  endfunction : interp

  logic signed [19:0] zero_v;
  logic signed [19:0] full_v;
  logic signed [19:0] off_v;
  logic signed [19:0] rise_v;
  logic signed [19:0] span_v;
  logic signed [35:0] scaled_v;
  logic [7:0] press_c;

  // offset, span and saturated scaling
  always_comb begin
    zero_v = interp(s_q.zero_lo, s_q.zero_hi, s_q.sup_lo, s_q.sup_hi, s_q.vsup);
    full_v = interp(s_q.full_lo, s_q.full_hi, s_q.sup_lo, s_q.sup_hi, s_q.vsup);
    off_v = s_q.dyn ? $signed({12'h000, s_q.dz}) : zero_v;
    rise_v = $signed({12'h000, s_q.avg}) - off_v;
    span_v = full_v - off_v;
    scaled_v = 36'sh000000000;
    if (rise_v <= 20'sh00000) begin
      press_c = 8'h00;
    end else if (span_v <= 20'sh00000) begin
      press_c = BYTE_MAX;
    end else begin
      // wide product so large extrapolated offsets still clamp
      scaled_v = (36'(rise_v) * $signed({28'h0000000, BYTE_MAX})) / 36'(span_v);
      press_c = (scaled_v > $signed({28'h0000000, BYTE_MAX})) ? BYTE_MAX : scaled_v[7:0];
    end
  end

  // ****************************************
  // next state
  // ****************************************
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic selected;
  logic [7:0] cmd;
  logic [11:0] sum;

  always_comb begin
    s_d = s_q;
    // two-stage synchronisers, third stage for edges
    s_d.sclk_s1 = spi_sclk_i;
    s_d.sclk_s2 = s_q.sclk_s1;
    s_d.sclk_s3 = s_q.sclk_s2;
    s_d.cs_s1 = spi_cs_n_i;
    s_d.cs_s2 = s_q.cs_s1;
    s_d.cs_s3 = s_q.cs_s2;
    s_d.mosi_s1 = spi_mosi_i;
    s_d.mosi_s2 = s_q.mosi_s1;
    sclk_rise = s_q.sclk_s2 & ~s_q.sclk_s3;
    sclk_fall = ~s_q.sclk_s2 & s_q.sclk_s3;
    cs_fall = ~s_q.cs_s2 & s_q.cs_s3;
    selected = ~s_q.cs_s2;
    cmd = {s_q.rx[6:0], s_q.mosi_s2};
    sum = s_q.acc + {4'h0, sample_i};

    // calibration store
    if (cal_load_i) begin
      s_d.zero_lo = cal_zero_lo_i;
      s_d.full_lo = cal_full_lo_i;
      s_d.sup_lo = cal_supply_lo_i;
      s_d.zero_hi = cal_zero_hi_i;
      s_d.full_hi = cal_full_hi_i;
      s_d.sup_hi = cal_supply_hi_i;
    end

    // sixteen-sample averaging
    if (sample_valid_i) begin
      if (s_q.cnt == AVG_LAST) begin
        s_d.avg = sum[11:AVG_SHIFT];
        s_d.vsup = supply_i;
        s_d.acc = 12'h000;
      end else begin
        s_d.acc = sum;
      end
      s_d.cnt = s_q.cnt + 4'h1;
    end

    s_d.press = press_c;
    s_d.miso_oe = selected;

    // serial link, sampled on rise, shifted on fall
    if (!selected) begin
      s_d.bitcnt = 4'h0;
    end else if (cs_fall) begin
      s_d.tx = s_q.reply;
      s_d.miso = s_q.reply[7];
      s_d.bitcnt = 4'h0;
    end else if (sclk_rise) begin
      s_d.rx = cmd;
      if (s_q.bitcnt == BITS_PER_BYTE - 4'h1) begin
        s_d.bitcnt = 4'h0;
        // command decode
        case (cmd)
          CMD_PRESSURE: s_d.reply = s_q.press;
          CMD_DYN_ZERO: begin
            s_d.dyn = 1'b1;
            s_d.dz = s_q.avg;
            s_d.reply = REPLY_UNKNOWN;
          end
          CMD_UNDO_ZERO: begin
            s_d.dyn = 1'b0;
            s_d.reply = REPLY_UNKNOWN;
          end
          CMD_RANGE: s_d.reply = RANGE_CODE;
          CMD_PART_ID: s_d.reply = PART_ID;
          CMD_SW_REV: s_d.reply = SW_REV;
          default: s_d.reply = REPLY_UNKNOWN;
        endcase
      end else begin
        s_d.bitcnt = s_q.bitcnt + 4'h1;
      end
    end else if (sclk_fall) begin
      if (s_q.bitcnt == 4'h0) begin
        s_d.tx = s_q.reply;
        s_d.miso = s_q.reply[7];
      end else begin
        s_d.tx = {s_q.tx[6:0], 1'b0};
        s_d.miso = s_q.tx[6];
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.sclk_s1 <= 1'b0;
      s_q.cs_s1 <= 1'b1;
      s_q.cs_s2 <= 1'b1;
      s_q.cs_s3 <= 1'b1;
      s_q.reply <= REPLY_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign spi_miso_o = s_q.miso;
  assign spi_miso_oe_o = s_q.miso_oe;
  assign dyn_zero_o = s_q.dyn;
  assign avg_o = s_q.avg;
endmodule : smart_pressure_spi_slave
`default_nettype wire

// *** tb/spi_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// spi master, mode 0, 400 ns half period
module spi_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'h0;
    cs_n_o = 1'h1;
    mosi_o = 1'h0;
  end
  // one select per byte, reply sampled on rise
  task automatic xfer(input logic [7:0] c, output logic [7:0] r);
    cs_n_o = 1'h0;
    #800;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = c[i];
      #400 sclk_o = 1'h1;
      r[i] = miso_i;
      #400 sclk_o = 1'h0;
    end
    #400 cs_n_o = 1'h1;
    mosi_o = ~mosi_o;
    #800;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// *** tb/pressure_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module pressure_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_valid_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic dyn_zero_o,
  input wire logic [7:0] avg_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_rst; disable iff (1'h0)
    rst_i |=> !avg_o && !dyn_zero_o && !spi_miso_oe_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_oe_off; spi_cs_n_i [*6] |-> !spi_miso_oe_o; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe while idle");
  property p_oe_on; spi_cs_n_i ##1 !spi_cs_n_i [*6] |-> spi_miso_oe_o; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe missing");
  property p_miso; !spi_cs_n_i && $changed(spi_miso_o) |-> !$past(spi_sclk_i, 2); endproperty
  a_miso: assert property (p_miso) else $error("miso moved");
  property p_avg; $changed(avg_o) |->
    $past(sample_valid_i) || $past(sample_valid_i, 2) || $past(rst_i); endproperty
  a_avg: assert property (p_avg) else $error("avg moved");
  property p_dz_up; $rose(dyn_zero_o) |-> !spi_cs_n_i; endproperty
  a_dz_up: assert property (p_dz_up) else $error("zero set");
  property p_dz_dn; $fell(dyn_zero_o) |-> !spi_cs_n_i || $past(rst_i); endproperty
  a_dz_dn: assert property (p_dz_dn) else $error("zero undone");
  property p_dz_hold; spi_cs_n_i [*6] |=> $stable(dyn_zero_o) || $past(rst_i); endproperty
  a_dz_hold: assert property (p_dz_hold) else $error("zero moved");
endmodule : pressure_assertions
bind smart_pressure_spi_slave pressure_assertions chk (.clk_i(clk_i), .rst_i(rst_i),
  .sample_valid_i(sample_valid_i), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .dyn_zero_o(dyn_zero_o),
  .avg_o(avg_o));
`default_nettype wire

// *** tb/smart_pressure_spi_slave_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module smart_pressure_spi_slave_test;
  import pressure_pkg::*;
  localparam logic [7:0] RNG = 8'h0a;
  localparam logic [7:0] PID = 8'h3c; // arbitrary value
  localparam logic [7:0] REV = 8'h02; // arbitrary value
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic sv = 1'h0;
  logic cl = 1'h0;
  logic [7:0] smp = 8'h00;
  logic [7:0] sup = 8'h00;
  logic [7:0] r;
  logic [7:0] c [6] = '{default: 8'h00};
  wire logic sclk, csn, mosi, miso, oe, dz;
  wire logic [7:0] avg;
  logic mw;
  int errors = 0;
  int num_checks = 0;
  assign mw = oe ? miso : 1'hz;
  smart_pressure_spi_slave #(.PART_ID(PID), .SW_REV(REV), .RANGE_CODE(RNG)) uut (
    .clk_i(clk), .rst_i(rst), .sample_valid_i(sv), .sample_i(smp), .supply_i(sup),
    .cal_load_i(cl), .cal_zero_lo_i(c[0]), .cal_full_lo_i(c[1]), .cal_supply_lo_i(c[2]),
    .cal_zero_hi_i(c[3]), .cal_full_hi_i(c[4]), .cal_supply_hi_i(c[5]), .spi_sclk_i(sclk),
    .spi_cs_n_i(csn), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe),
    .dyn_zero_o(dz), .avg_o(avg));
  spi_host_model host (.sclk_o(sclk), .cs_n_o(csn), .mosi_o(mosi), .miso_i(mw));
  initial forever #50 clk = ~clk;
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task feed(input logic [7:0] a, input logic [7:0] b, input logic [7:0] s);
    sup = s;
    for (int i = 0; i < 16; i++) begin
      smp = i[0] ? a : b;
      sv = 1'h1;
      @(posedge clk) #1;
    end
    sv = 1'h0;
    repeat (3) @(posedge clk) #1;
  endtask : feed
  task cal(input logic [7:0] z0, f0, z1, f1);
    c = '{z0, f0, 8'h40, z1, f1, 8'hc0};
    cl = 1'h1;
    @(posedge clk) #1;
    cl = 1'h0;
  endtask : cal
  task x(input logic [7:0] cmd, input logic [7:0] e);
    host.xfer(cmd, r);
    chk(r, e);
  endtask : x
  task t_avg;
    chk(avg, 8'h00);
    cal(8'h00, 8'hff, 8'h00, 8'hff);
    feed(8'h48, 8'h58, 8'h80);
    chk(avg, 8'h50);
    host.xfer(CMD_PRESSURE, r);
    x(CMD_RANGE, 8'h50);
    $display("avg test done");
  endtask : t_avg
  task t_codes;
    x(CMD_PART_ID, RNG);
    x(CMD_SW_REV, PID);
    x(8'h09, REV);
    x(CMD_DYN_ZERO, 8'h00);
    $display("codes test done");
  endtask : t_codes
  task t_zero;
    chk({7'h00, dz}, 8'h01);
    x(CMD_PRESSURE, 8'h00);
    x(CMD_UNDO_ZERO, 8'h00);
    chk({7'h00, dz}, 8'h00);
    x(CMD_PRESSURE, 8'h00);
    x(CMD_PRESSURE, 8'h50);
    $display("zero test done");
  endtask : t_zero
  task t_comp;
    feed(8'hff, 8'hff, 8'h80);
    cal(8'h00, 8'h80, 8'h00, 8'h80);
    x(CMD_PRESSURE, 8'h50);
    x(CMD_PRESSURE, 8'hff);
    cal(8'h00, 8'hff, 8'h20, 8'hff);
    feed(8'h10, 8'h10, 8'h80);
    x(CMD_PRESSURE, 8'hff);
    x(8'h00, 8'h00);
    feed(8'h10, 8'h10, 8'h40);
    x(CMD_PRESSURE, 8'h00);
    x(8'h00, 8'h10);
    $display("comp test done");
  endtask : t_comp
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // watchdog
  initial begin
    #1000000;
    errors++;
    print_verdict;
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'h0;
    repeat (4) @(posedge clk) #1;
    t_avg;
    t_codes;
    t_zero;
    t_comp;
    print_verdict;
  end
endmodule : smart_pressure_spi_slave_test
`default_nettype wire
